/* logic/rpi_map.vh */
// register offsets, field positions, reset values and timing figures
// assumes a 10 MHz clock and a 32-bit APB register bus
`ifndef RPI_MAP_VH
`define RPI_MAP_VH

// ****************************************
// clock and timing figures
// ****************************************
`define RPI_CYC_PER_MS  32'd10000
`define RPI_IDLE_MS     32'd300000
`define RPI_AC_LOSS_MS  32'd10000
`define RPI_REPEAT_MS   32'd500
`define RPI_DEB_MS      32'd20
`define RPI_HOLD_MS     32'd1000
`define RPI_FLASH_MS    32'd500

// ****************************************
// display geometry
// ****************************************
`define RPI_LCD_LINES   3'd4
`define RPI_LCD_COLS    5'd20
`define RPI_SCREEN_MAX  6'd37
`define RPI_SCREEN_FLT  6'd1

// ****************************************
// register offsets and reset values
// ****************************************
`define RPI_OFS_CTRL    8'h00
`define RPI_OFS_STATUS  8'h04
`define RPI_OFS_SCREEN  8'h08
`define RPI_CTRL_RST    2'h0
`define RPI_CTRL_AUTORST 0
`define RPI_CTRL_CLPUEN  1
`define RPI_STAT_PSAVE   24

// ****************************************
// key index and lamp field positions
// ****************************************
`define RPI_KEY_TRIP    0
`define RPI_KEY_CLOSE   1
`define RPI_KEY_NEXT    2
`define RPI_KEY_BACK    3
`define RPI_KEY_RSTTGT  4
`define RPI_KEYS        5
`define RPI_LED_OK      0
`define RPI_LED_AC      1
`define RPI_LED_AMT     2
`define RPI_LED_BATT    3
`define RPI_LED_MALF    4
`define RPI_LED_REV     5
`define RPI_LED_TGT     6
`define RPI_LED_VOLT    11
`define RPI_LED_CLOSED  14
`define RPI_LED_OPEN    15
`define RPI_LED_LOCK    16
`define RPI_LED_HOTLINE 17
`define RPI_LEDS        18

`endif

/* logic/rpi_sync2.v */
// two flip-flop synchroniser for levels arriving from pins
// assumes the inputs are quasi-static compared with the clock
`timescale 1ns/1ps
`default_nettype none
module rpi_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             clock,
  input  wire             rstn,
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always @(posedge clock) begin
    if (!rstn) begin
      stage1  <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      stage1  <= pinIn;
      syncOut <= stage1;
    end
  end

endmodule
`default_nettype wire

/* logic/rpi_key_filter.v */
// one panel key: synchroniser, debounce, press pulse, hold repeat
// assumes an active-high key level from a pin; HOLD_CYC >= RPT_CYC
`timescale 1ns/1ps
`default_nettype none
module rpi_key_filter #(
  parameter [31:0] DEB_CYC  = 32'd200000,
  parameter [31:0] HOLD_CYC = 32'd10000000,
  parameter [31:0] RPT_CYC  = 32'd5000000
) (
  input  wire clock,
  input  wire rstn,
  input  wire keyPin,
  output reg  keyLevel,
  output reg  keyPress,
  output reg  keyRepeat
);

  wire        keySync;
  reg  [31:0] debCnt;
  reg  [31:0] holdCnt;

  // ****************************************
  // pin synchroniser
  // ****************************************
  rpi_sync2 #(.WIDTH(1)) u_sync (
    .clock   (clock),
    .rstn    (rstn),
    .pinIn   (keyPin),
    .syncOut (keySync)
  );

  // ****************************************
  // debounce, press edge and hold repeat
  // ****************************************
  always @(posedge clock) begin
    if (!rstn) begin
      debCnt    <= 32'h0;
      holdCnt   <= 32'h0;
      keyLevel  <= 1'b0;
      keyPress  <= 1'b0;
      keyRepeat <= 1'b0;
    end else begin
      keyPress  <= 1'b0;
      keyRepeat <= 1'b0;
      if (keySync == keyLevel) begin
        debCnt <= 32'h0;
      end else if (debCnt >= DEB_CYC) begin
        debCnt   <= 32'h0;
        keyLevel <= keySync;
        keyPress <= keySync; // R23
      end else begin
        debCnt <= debCnt + 32'h1;
      end
      // one fixed hold threshold, then a steady repeat
      if (!keyLevel) begin
        holdCnt <= 32'h0;
      end else if (holdCnt >= HOLD_CYC) begin
        holdCnt   <= HOLD_CYC - RPT_CYC; // R23
        keyRepeat <= 1'b1;
      end else begin
        holdCnt <= holdCnt + 32'h1;
      end
    end
  end

endmodule
`default_nettype wire

/* logic/rpi_panel.v */
// operator panel controller: lamps, pushbuttons, power save, screens
// assumes core flags on this clock, keys and sensors from pins
// Behaviour
// R1: blank lamps after five idle minutes; here the hot line tag, open and closed lamps stay lit
// R2: key press wakes panel; backlight off asleep
// R3: healthy lamp only without self-test fault
// R4: AC lamp; off after 10 s absence
// R5: above-minimum lamp from any channel
// R6: battery lamp below 20 V or sag
// R7: failed battery test latches until pass
// R8: malfunction lamp until commanded state reached
// R9: reverse-power lamp follows reverse flow
// R10: latch target on trip with pickup
// R11: clear targets by auto-reset or key
// R12: three bushing voltage lamps follow inputs
// R13: closed and open lamps follow mechanism
// R14: lockout lamp when open idle or handle
// R15: trip failure flashes four status lamps
// R16: trip key opens and locks out
// R17: close key homes sequence and closes
// R18: cold load pickup on lockout close press
// R19: close key ignored while already closed
// R20: screens of four lines, twenty characters
// R21: overcurrent trip jumps to first screen
// R22: next advances; holding repeats twice per second
// R23: keys debounced, fixed hold threshold
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rpi_map.vh"
module rpi_panel #(
  parameter [31:0] IDLE_CYC  = `RPI_IDLE_MS * `RPI_CYC_PER_MS,
  parameter [31:0] AC_CYC    = `RPI_AC_LOSS_MS * `RPI_CYC_PER_MS,
  parameter [31:0] RPT_CYC   = `RPI_REPEAT_MS * `RPI_CYC_PER_MS,
  parameter [31:0] DEB_CYC   = `RPI_DEB_MS * `RPI_CYC_PER_MS,
  parameter [31:0] HOLD_CYC  = `RPI_HOLD_MS * `RPI_CYC_PER_MS,
  parameter [31:0] FLASH_CYC = `RPI_FLASH_MS * `RPI_CYC_PER_MS
) (
  input  wire                 clock,
  input  wire                 rstn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [7:0]           paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output wire                 pready,
  output wire                 pslverr,
  input  wire [`RPI_KEYS-1:0] keyPin,
  input  wire                 hotLineTagPin,
  input  wire                 acSensePin,
  input  wire [2:0]           bushVoltPin,
  input  wire                 mechClosedPin,
  input  wire                 mechOpenPin,
  input  wire                 handleDownPin,
  input  wire                 selfTestOk,
  input  wire [4:0]           aboveMinTrip,
  input  wire                 battLow,
  input  wire                 battTestDone,
  input  wire                 battTestFail,
  input  wire                 reverseFlow,
  input  wire                 ocTrip,
  input  wire                 tripFail,
  input  wire                 closeFail,
  input  wire                 seqActive,
  input  wire                 clpuBlocked,
  output reg  [`RPI_LEDS-1:0] leds,
  output reg                  backlight,
  output reg                  powerSave,
  output reg                  tripCmd,
  output reg                  lockoutCmd,
  output reg                  closeCmd,
  output reg                  seqHomeCmd,
  output reg                  cold_load_pickup,
  output reg  [5:0]           screenNum,
  output reg  [1:0]           lcdLine,
  output reg  [4:0]           lcdCol
);

  wire [`RPI_KEYS-1:0] keyPress, keyRepeat;
  wire [7:0]           pinSync;
  wire                 hotLine, acOn, mechClosed, mechOpen, handleDown;
  wire [2:0]           bushVolt;
  reg  [1:0]           ctrlReg;
  reg  [31:0]          idleCnt, acCnt, flashCnt;
  reg                  acLamp, battLatch, malf, wantOpen, closedPrev, blink;
  reg  [4:0]           targets;
  reg  [`RPI_LEDS-1:0] next_leds;
  wire                 anyPress, closedRise, lockState, tripFlash, apbAccess, apbHit;

  // wraps a screen number forward or back within 1..max
  function [5:0] stepScreen;
    input [5:0] cur;
    input       fwd;
    begin
      if (fwd) begin
        stepScreen = (cur >= `RPI_SCREEN_MAX) ? 6'd1 : cur + 6'd1;
      end else begin
        stepScreen = (cur <= 6'd1) ? `RPI_SCREEN_MAX : cur - 6'd1;
      end
    end
  endfunction

  // ****************************************
  // key filters and pin synchronisers
  // ****************************************
  genvar k;
  generate
    for (k = 0; k < `RPI_KEYS; k = k + 1) begin : g_key
      rpi_key_filter #(.DEB_CYC(DEB_CYC), .HOLD_CYC(HOLD_CYC), .RPT_CYC(RPT_CYC)) u_key (
        .clock     (clock),
        .rstn      (rstn),
        .keyPin    (keyPin[k]),
        .keyLevel  (),
        .keyPress  (keyPress[k]),
        .keyRepeat (keyRepeat[k])
      );
    end
  endgenerate

  rpi_sync2 #(.WIDTH(8)) u_pins (
    .clock   (clock),
    .rstn    (rstn),
    .pinIn   ({hotLineTagPin, handleDownPin, mechOpenPin, mechClosedPin,
               bushVoltPin, acSensePin}),
    .syncOut (pinSync)
  );

  assign acOn       = pinSync[0];
  assign bushVolt   = pinSync[3:1];
  assign mechClosed = pinSync[4];
  assign mechOpen   = pinSync[5];
  assign handleDown = pinSync[6];
  assign hotLine    = pinSync[7];

  // shared event terms
  assign anyPress   = |keyPress;
  assign closedRise = mechClosed & ~closedPrev;
  assign lockState  = (mechOpen & ~seqActive) | handleDown; // R14
  assign tripFlash  = malf & wantOpen;

  // ****************************************
  // APB slave: zero wait, error on unmapped
  // ****************************************
  assign apbAccess = psel & penable;
  assign apbHit    = (paddr == `RPI_OFS_CTRL) | (paddr == `RPI_OFS_STATUS) |
                     (paddr == `RPI_OFS_SCREEN);
  assign pready    = 1'b1;
  assign pslverr   = apbAccess & ~apbHit;

  // read data captured in the setup cycle
  always @(posedge clock) begin
    if (!rstn) begin
      prdata <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `RPI_OFS_CTRL:   prdata <= {30'h0, ctrlReg};
        `RPI_OFS_STATUS: prdata <= {7'h0, powerSave, 6'h0, leds};
        `RPI_OFS_SCREEN: prdata <= {26'h0, screenNum};
        default:         prdata <= 32'h0;
      endcase
    end
  end

  // control bits: auto reset of targets, cold load enable
  always @(posedge clock) begin
    if (!rstn) begin
      ctrlReg <= `RPI_CTRL_RST;
    end else if (apbAccess & pwrite & (paddr == `RPI_OFS_CTRL)) begin
      ctrlReg <= pwdata[1:0];
    end
  end

  // ****************************************
  // inactivity timer and backlight
  // ****************************************
  always @(posedge clock) begin
    if (!rstn) begin
      idleCnt   <= 32'h0;
      powerSave <= 1'b0;
      backlight <= 1'b1;
    end else if (anyPress) begin
      idleCnt   <= 32'h0;
      powerSave <= 1'b0; // R2
      backlight <= 1'b1; // R2
    end else if (idleCnt >= IDLE_CYC) begin
      powerSave <= 1'b1; // R1
      backlight <= 1'b0; // R2
    end else begin
      idleCnt <= idleCnt + 32'h1;
    end
  end

  // ****************************************
  // ac presence with loss hold-off
  // ****************************************
  always @(posedge clock) begin
    if (!rstn) begin
      acCnt  <= 32'h0;
      acLamp <= 1'b0;
    end else if (acOn) begin
      acCnt  <= 32'h0;
      acLamp <= 1'b1; // R4
    end else if (acCnt >= AC_CYC) begin
      acLamp <= 1'b0; // R4
    end else begin
      acCnt <= acCnt + 32'h1;
    end
  end

  // ****************************************
  // battery test latch
  // ****************************************
  always @(posedge clock) begin
    if (!rstn) begin
      battLatch <= 1'b0;
    end else if (battTestDone) begin
      battLatch <= battTestFail; // R7
    end
  end

  // ****************************************
  // malfunction tracking, new failure wins
  // ****************************************
  always @(posedge clock) begin
    if (!rstn) begin
      malf     <= 1'b0;
      wantOpen <= 1'b0;
    end else if (tripFail | closeFail) begin
      malf     <= 1'b1; // R8
      wantOpen <= tripFail;
    end else if (malf & (wantOpen ? mechOpen : mechClosed)) begin
      malf <= 1'b0; // R8
    end
  end

  // ****************************************
  // fault targets, setting beats clearing
  // ****************************************
  always @(posedge clock) begin
    if (!rstn) begin
      targets    <= 5'h0;
      closedPrev <= 1'b0;
    end else begin
      closedPrev <= mechClosed;
      if (keyPress[`RPI_KEY_RSTTGT] |
          (closedRise & ctrlReg[`RPI_CTRL_AUTORST])) begin
        targets <= ocTrip ? aboveMinTrip : 5'h0; // R11
      end else if (ocTrip) begin
        targets <= targets | aboveMinTrip; // R10
      end
    end
  end

  // ****************************************
  // flash time base
  // ****************************************
  always @(posedge clock) begin
    if (!rstn) begin
      flashCnt <= 32'h0;
      blink    <= 1'b0;
    end else if (flashCnt >= FLASH_CYC - 32'h1) begin
      flashCnt <= 32'h0;
      blink    <= ~blink;
    end else begin
      flashCnt <= flashCnt + 32'h1;
    end
  end

  // ****************************************
  // lamp composition and power save gating
  // ****************************************
  always @* begin
    next_leds                       = {`RPI_LEDS{1'b0}};
    next_leds[`RPI_LED_OK]          = selfTestOk; // R3
    next_leds[`RPI_LED_AC]          = acLamp; // R4
    next_leds[`RPI_LED_AMT]         = |aboveMinTrip; // R5
    next_leds[`RPI_LED_BATT]        = battLow | battLatch; // R6
    next_leds[`RPI_LED_MALF]        = malf; // R8
    next_leds[`RPI_LED_REV]         = reverseFlow; // R9
    next_leds[`RPI_LED_TGT+4:`RPI_LED_TGT]   = targets; // R10
    next_leds[`RPI_LED_VOLT+2:`RPI_LED_VOLT] = bushVolt; // R12
    next_leds[`RPI_LED_CLOSED]      = mechClosed; // R13
    next_leds[`RPI_LED_OPEN]        = mechOpen; // R13
    next_leds[`RPI_LED_LOCK]        = lockState; // R14
    next_leds[`RPI_LED_HOTLINE]     = hotLine;
    if (tripFlash) begin
      next_leds[`RPI_LED_MALF]   = blink; // R15
      next_leds[`RPI_LED_OPEN]   = blink; // R15
      next_leds[`RPI_LED_CLOSED] = blink; // R15
      next_leds[`RPI_LED_LOCK]   = blink; // R15
    end
    if (powerSave) begin
      // only tag and mechanism status stay lit
      next_leds = next_leds & ((`RPI_LEDS'h1 << `RPI_LED_HOTLINE) |
                               (`RPI_LEDS'h1 << `RPI_LED_OPEN) |
                               (`RPI_LEDS'h1 << `RPI_LED_CLOSED)); // R1
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      leds <= {`RPI_LEDS{1'b0}};
    end else begin
      leds <= next_leds;
    end
  end

  // ****************************************
  // trip and close pushbuttons
  // ****************************************
  always @(posedge clock) begin
    if (!rstn) begin
      tripCmd          <= 1'b0;
      lockoutCmd       <= 1'b0;
      closeCmd         <= 1'b0;
      seqHomeCmd       <= 1'b0;
      cold_load_pickup <= 1'b0;
    end else begin
      tripCmd    <= keyPress[`RPI_KEY_TRIP]; // R16
      lockoutCmd <= keyPress[`RPI_KEY_TRIP]; // R16
      // close press only; repeats from holding are ignored
      if (keyPress[`RPI_KEY_CLOSE] & ~mechClosed) begin // R19
        closeCmd         <= 1'b1; // R17
        seqHomeCmd       <= 1'b1; // R17
        cold_load_pickup <= lockState & ~clpuBlocked & ctrlReg[`RPI_CTRL_CLPUEN]; // R18
      end else begin
        closeCmd         <= 1'b0;
        seqHomeCmd       <= 1'b0;
        cold_load_pickup <= 1'b0;
      end
    end
  end

  // ****************************************
  // screen navigation
  // ****************************************
  always @(posedge clock) begin
    if (!rstn) begin
      screenNum <= `RPI_SCREEN_FLT;
    end else if (ocTrip) begin
      screenNum <= `RPI_SCREEN_FLT; // R21
    end else if (keyPress[`RPI_KEY_NEXT] | keyRepeat[`RPI_KEY_NEXT]) begin
      screenNum <= stepScreen(screenNum, 1'b1); // R22
    end else if (keyPress[`RPI_KEY_BACK] | keyRepeat[`RPI_KEY_BACK]) begin
      screenNum <= stepScreen(screenNum, 1'b0);
    end
  end

  // ****************************************
  // character scan over four lines of twenty
  // ****************************************
  always @(posedge clock) begin
    if (!rstn) begin
      lcdLine <= 2'h0;
      lcdCol  <= 5'h0;
    end else if (lcdCol >= `RPI_LCD_COLS - 5'd1) begin
      lcdCol <= 5'h0; // R20
      if ({1'b0, lcdLine} >= `RPI_LCD_LINES - 3'd1) begin
        lcdLine <= 2'h0; // R20
      end else begin
        lcdLine <= lcdLine + 2'h1;
      end
    end else begin
      lcdCol <= lcdCol + 5'h1;
    end
  end

endmodule
`default_nettype wire

/* sim/rpi_panel_assertions.sv */
// concurrent checks on the panel controller ports
// assumes binding onto rpi_panel, one clock, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "rpi_map.vh"
module rpi_panel_assertions (
  input wire logic                 clock,
  input wire logic                 rstn,
  input wire logic [`RPI_LEDS-1:0] leds,
  input wire logic                 backlight,
  input wire logic                 powerSave,
  input wire logic                 tripCmd,
  input wire logic                 lockoutCmd,
  input wire logic                 closeCmd,
  input wire logic                 seqHomeCmd,
  input wire logic                 cold_load_pickup,
  input wire logic                 clpuBlocked,
  input wire logic                 selfTestOk,
  input wire logic                 reverseFlow,
  input wire logic [4:0]           aboveMinTrip,
  input wire logic                 ocTrip,
  input wire logic [5:0]           screenNum,
  input wire logic [1:0]           lcdLine,
  input wire logic [4:0]           lcdCol
);
  // ****
  // command, lamp, screen and character scan relations
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_trip_locks: assert property (tripCmd |-> lockoutCmd)
    else $error("trip without lockout");
  chk_close_homes: assert property (closeCmd |-> seqHomeCmd)
    else $error("close without home");
  chk_cold_load_pickup_free: assert property (cold_load_pickup |-> !$past(clpuBlocked))
    else $error("cold load start while blocked");
  chk_sleep_dark: assert property (powerSave && $past(powerSave) |-> leds[16:0] == 17'h08000 ||
    leds[16:0] == 17'h04000 || leds[16:0] == 17'h0C000 || leds[16:0] == 17'h00000)
    else $error("lamps lit in power save");
  chk_sleep_backlight: assert property (powerSave && $past(powerSave) |-> !backlight)
    else $error("backlight on in power save");
  chk_ok_lamp: assert property ($past(rstn) && !powerSave && !$past(powerSave)
    |-> leds[0] == $past(selfTestOk))
    else $error("healthy lamp mismatch");
  chk_rev_lamp: assert property ($past(rstn) && !powerSave && !$past(powerSave)
    |-> leds[5] == $past(reverseFlow))
    else $error("reverse lamp mismatch");
  chk_amt_lamp: assert property ($past(rstn) && !powerSave && !$past(powerSave)
    |-> leds[2] == |$past(aboveMinTrip))
    else $error("above minimum lamp mismatch");
  chk_oc_screen: assert property (ocTrip |=> screenNum == 6'h01)
    else $error("trip did not show first screen");
  chk_screen_range: assert property (screenNum >= 6'h01 && screenNum <= 6'h25)
    else $error("screen number out of range");
  chk_lcd_step: assert property (lcdCol != 5'h13 |=> lcdCol == $past(lcdCol) + 5'h1)
    else $error("character column did not step");
  chk_lcd_wrap: assert property (lcdCol == 5'h13 |=> lcdCol == 5'h00 &&
    lcdLine == $past(lcdLine) + 2'h1)
    else $error("character scan did not wrap");
endmodule
bind rpi_panel rpi_panel_assertions u_chk (.clock, .rstn, .leds, .backlight, .powerSave,
  .tripCmd, .lockoutCmd, .closeCmd, .seqHomeCmd, .cold_load_pickup, .clpuBlocked,
  .selfTestOk, .reverseFlow, .aboveMinTrip, .ocTrip, .screenNum, .lcdLine, .lcdCol);
`default_nettype wire

/* sim/rpi_mech_model.sv */
// recloser mechanism: answers trip and close commands after a travel time
// assumes one-cycle command pulses; stuck holds it in place to fake a failure
`timescale 1ns/1ps
`default_nettype none
module rpi_mech_model #(
  parameter int DLY = 5
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic tripCmd,
  input  wire logic closeCmd,
  input  wire logic stuck,
  output logic      mechClosedPin,
  output logic      mechOpenPin
);
  logic       goClosed;
  logic [7:0] travel;
  // both contacts low while travelling
  always @(posedge clock) begin
    if (!rstn) begin
      travel <= 8'h00;
      goClosed <= 1'b0;
      mechOpenPin <= 1'b1;
      mechClosedPin <= 1'b0;
    end else if (!stuck && (tripCmd || closeCmd)) begin
      goClosed <= closeCmd;
      travel <= 8'(DLY);
      mechOpenPin <= 1'b0;
      mechClosedPin <= 1'b0;
    end else if (travel == 8'h01) begin
      mechClosedPin <= goClosed;
      mechOpenPin <= !goClosed;
      travel <= 8'h00;
    end else if (travel != 8'h00) begin
      travel <= travel - 8'h01;
    end
  end
endmodule
`default_nettype wire

/* sim/rpi_panel_test.sv */
// self-checking bench for the panel controller
// assumes shortened timing parameters and the mechanism model
`timescale 1ns/1ps
`default_nettype none
module rpi_panel_test;
  localparam int IDLE = 200, AC = 50, RPT = 8, HOLD = 16;
  logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, backlight, powerSave, tripCmd, lockoutCmd;
  logic closeCmd, seqHomeCmd, cold_load_pickup, stuck = 0, s0, s1;
  logic [4:0] keyPin = 5'h00, aboveMinTrip = 5'h00;
  logic hotLineTagPin = 1, acSensePin = 0, mechClosedPin, mechOpenPin;
  logic [2:0] bushVoltPin = 3'h0;
  logic handleDownPin = 0, selfTestOk = 0, battLow = 0, battTestDone = 0;
  logic battTestFail = 0, reverseFlow = 0, ocTrip = 0, tripFail = 0;
  logic closeFail = 0, seqActive = 0, clpuBlocked = 0;
  logic [17:0] leds;
  logic [5:0] screenNum;
  int errors = 0, checks = 0, cyc = 0, nTrip = 0, nLock = 0, nClose = 0;
  int nHome = 0, nClpu = 0, w;

  rpi_panel #(.IDLE_CYC(IDLE), .AC_CYC(AC), .RPT_CYC(RPT), .DEB_CYC(3), .HOLD_CYC(HOLD),
    .FLASH_CYC(4)) uut (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .keyPin, .hotLineTagPin, .acSensePin, .bushVoltPin,
    .mechClosedPin, .mechOpenPin, .handleDownPin, .selfTestOk, .aboveMinTrip, .battLow,
    .battTestDone, .battTestFail, .reverseFlow, .ocTrip, .tripFail, .closeFail, .seqActive,
    .clpuBlocked, .leds, .backlight, .powerSave, .tripCmd, .lockoutCmd, .closeCmd,
    .seqHomeCmd, .cold_load_pickup, .screenNum, .lcdLine(), .lcdCol());
  rpi_mech_model #(.DLY(5)) mech (.clock, .rstn, .tripCmd, .closeCmd, .stuck,
    .mechClosedPin, .mechOpenPin);

  // ****
  // clock, command counters, timeout
  // ****
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (tripCmd === 1'b1) nTrip++;
    if (lockoutCmd === 1'b1) nLock++;
    if (closeCmd === 1'b1) nClose++;
    if (seqHomeCmd === 1'b1) nHome++;
    if (cold_load_pickup === 1'b1) nClpu++;
    if (cyc == 5000) begin
      errors++;
      stop_test;
    end
  end

  // ****
  // shared tasks
  // ****
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task press(input int k);
    @(posedge clock);
    keyPin[k] <= 1'b1;
    repeat (12) @(posedge clock);
    keyPin[k] <= 1'b0;
    repeat (12) @(posedge clock);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****
  // scenarios
  // ****
  task t_regs;
    apb(1'b0, 8'h00, 32'h0); chk("ctrl", 0, rd);
    apb(1'b0, 8'h08, 32'h0); chk("screen", 1, rd);
    apb(1'b0, 8'h0C, 32'h0); chk("slverr", 1, err);
    apb(1'b1, 8'h00, 32'h3); apb(1'b0, 8'h00, 32'h0); chk("ctrlrw", 3, rd);
    apb(1'b0, 8'h04, 32'h0); chk("psbit", 0, rd[24]);
    $display("test regs done");
  endtask
  task t_lamps;
    @(posedge clock);
    {selfTestOk, reverseFlow, acSensePin, battLow} <= 4'hF;
    aboveMinTrip <= 5'h10;
    bushVoltPin <= 3'h5;
    repeat (5) @(posedge clock);
    chk("ok", 1, leds[0]); chk("amt", 1, leds[2]);
    chk("batt", 1, leds[3]); chk("rev", 1, leds[5]);
    chk("bush", 5, leds[13:11]);
    {selfTestOk, acSensePin, battLow, battTestDone, battTestFail} <= 5'h03;
    @(posedge clock);
    {battTestDone, battTestFail} <= 2'h0;
    repeat (5) @(posedge clock);
    chk("okoff", 0, leds[0]); chk("battlatch", 1, leds[3]);
    repeat (AC - 10) @(posedge clock);
    chk("acheld", 1, leds[1]);
    repeat (12) @(posedge clock);
    chk("acoff", 0, leds[1]);
    battTestDone <= 1'b1;
    @(posedge clock);
    {battTestDone, reverseFlow, aboveMinTrip} <= 7'h00;
    repeat (4) @(posedge clock);
    chk("battpass", 0, leds[3]); chk("amtoff", 0, leds[2]);
    $display("test lamps done");
  endtask
  task t_trip;
    press(0);
    chk("trip", 1, nTrip); chk("lockcmd", 1, nLock); chk("lockled", 1, leds[16]);
    $display("test trip done");
  endtask
  task t_next;
    @(posedge clock);
    keyPin[2] <= 1'b1;
    w = 0;
    while (screenNum !== 6'h02 && w < 40) begin
      @(posedge clock);
      w++;
    end
    repeat (HOLD - 2) @(posedge clock);
    chk("nohold", 2, screenNum);
    repeat (4) @(posedge clock);
    chk("rep1", 3, screenNum);
    repeat (RPT) @(posedge clock);
    chk("rep2", 4, screenNum);
    keyPin[2] <= 1'b0;
    repeat (12) @(posedge clock);
    $display("test next done");
  endtask
  task t_targets;
    @(posedge clock);
    {aboveMinTrip, ocTrip} <= 6'h0B;
    @(posedge clock);
    {aboveMinTrip, ocTrip} <= 6'h00;
    repeat (3) @(posedge clock);
    chk("tgt", 5, leds[10:6]); chk("fltscr", 1, screenNum);
    press(4);
    chk("tgtclr", 0, leds[10:6]);
    {aboveMinTrip, ocTrip} <= 6'h25;
    @(posedge clock);
    {aboveMinTrip, ocTrip} <= 6'h00;
    repeat (3) @(posedge clock);
    chk("tgt2", 5'h12, leds[10:6]);
    $display("test targets done");
  endtask
  task t_close;
    press(1);
    chk("close", 1, nClose); chk("home", 1, nHome); chk("cold_load_pickup", 1, nClpu);
    chk("closed", 3'h1, leds[16:14]); chk("autoclr", 0, leds[10:6]);
    press(1);
    chk("noclose", 1, nClose);
    $display("test close done");
  endtask
  task t_fail;
    stuck <= 1'b1;
    press(0);
    tripFail <= 1'b1;
    @(posedge clock);
    tripFail <= 1'b0;
    {s0, s1} = 2'b00;
    repeat (12) begin
      @(posedge clock);
      if (leds[4] === 1'b1) s1 = 1'b1;
      else if (s1) s0 = 1'b1;
    end
    chk("flash", 3, {s1, s0});
    stuck <= 1'b0;
    press(0);
    chk("open", 2'h2, leds[15:14]); chk("malfclr", 0, leds[4]);
    $display("test fail done");
  endtask
  task t_psave;
    repeat (IDLE + 20) @(posedge clock);
    chk("ps", 1, powerSave); chk("bloff", 0, backlight);
    chk("dark", 18'h28000, leds);
    press(3);
    chk("wake", 0, powerSave); chk("blon", 1, backlight);
    chk("back", 37, screenNum);
    $display("test psave done");
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    t_regs;
    t_lamps;
    t_trip;
    t_next;
    t_targets;
    t_close;
    t_fail;
    t_psave;
    stop_test;
  end
endmodule
`default_nettype wire
